// ===== oirr_defines.svh
`ifndef OIRR_DEFINES_SVH
`define OIRR_DEFINES_SVH

// ==========================================================
// register offsets (byte addresses)
`define OIRR_VER_OFS 8'h00
`define OIRR_ROM_OFS 8'h04
`define OIRR_RTRY_OFS 8'h08

// ==========================================================
// field positions
`define OIRR_PRESENT_BIT 24
`define OIRR_CLEAR_BIT 31
`define OIRR_GO_BIT 25
`define OIRR_BYTE_LSB 16
`define OIRR_MINI_BIT 5
`define OIRR_LIMIT_W 4

// ==========================================================
// constant field values and reset values
`define OIRR_MAJOR 8'h01
`define OIRR_MINOR 8'h10
`define OIRR_MINI_PTR 8'h20
`define OIRR_MINI_NONE 8'h00
`define OIRR_MINI_BYTE 8'h06
`define OIRR_RTRY_RESET 12'h000
`define OIRR_UNITS 3

`endif

// ===== oirr_pkg.sv
`default_nettype none

package oirr_pkg;

  // ==========================================================
  // rom sequencer states
  typedef enum logic [2:0] {
    ST_BOOT,
    ST_LOAD,
    ST_IDLE,
    ST_CLEAR,
    ST_FETCH
  } oirr_state_type;

endpackage

`default_nettype wire

// ===== oirr_regs.sv
// Behaviour
// - version word bits 31:25 and 15:8 always read zero.
// - version bit 24 reads 1 when a serial rom was detected, else 0.
// - with a rom present, bus info block loads itself after hardware reset.
// - version bits 23:16 read constant 01h.
// - version bits 7:0 read constant 10h.
// - rom access register is only meaningful when the present bit is 1.
// - writing 1 to bit 31 zeroes rom address; hardware clears bit when done.
// - address clear does not fetch byte zero; read byte keeps old value.
// - writing 1 to bit 25 reads current byte; hardware clears it when done.
// - fetched rom byte lands in bits 23:16, written by hardware only.
// - rom access bits 30:26, 24 and 15:8 always read zero.
// - mini image pointer bits 7:0 read zero by default.
// - if rom byte 6h bit 5 is set, pointer reads 20h.
// - retry register bits 31:29 read zero.
// - retry register bits 28:16 read zero.
// - retry register bits 15:12 read zero.
// - bits 11:8 limit physical response unit retries after busy or data error.
// - bits 7:4 limit async response unit retries after busy or data error.
// - bits 3:0 limit async request unit retries after busy or data error.

`include "oirr_defines.svh"
`default_nettype none

module oirr_regs
  import oirr_pkg::*;
#(
  parameter int ROM_AW = 8,
  parameter int BIB_BYTES = 16
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // serial rom byte port
  input wire logic romDetected,
  output logic romReq,
  output logic [ROM_AW-1:0] romAddr,
  input wire logic romAck,
  input wire logic [7:0] romData,
  // bus information block
  output logic [8*BIB_BYTES-1:0] busInfoBlock,
  output logic busInfoValid,
  // transmit units: 0 request, 1 async response, 2 physical response
  input wire logic [`OIRR_UNITS-1:0] unitAttemptDone,
  input wire logic [`OIRR_UNITS-1:0] unitAckRetryable,
  input wire logic [`OIRR_UNITS*4-1:0] unitAckCode,
  output logic [`OIRR_UNITS-1:0] unitRetry,
  output logic [`OIRR_UNITS-1:0] unitComplete,
  output logic [`OIRR_UNITS*4-1:0] unitStatus
);

  // ==========================================================
  // declarations
  oirr_state_type state;
  logic romPresent;
  logic miniFlag;
  logic addrClear;
  logic readGo;
  logic [ROM_AW-1:0] byteAddr;
  logic [ROM_AW-1:0] loadIdx;
  logic [7:0] readByte;
  logic [`OIRR_UNITS*4-1:0] retryLimits;
  logic [`OIRR_LIMIT_W-1:0] retryCnt [`OIRR_UNITS];
  logic [31:0] readMux;
  logic romWrite;
  logic rtryWrite;
  logic loadLast;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  assign romWrite = regWrite && hit(regAddr, `OIRR_ROM_OFS);
  assign rtryWrite = regWrite && hit(regAddr, `OIRR_RTRY_OFS);
  assign loadLast = loadIdx == ROM_AW'(BIB_BYTES - 1);

  // ==========================================================
  // rom sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_BOOT;
    end else if (clkEn) begin
      case (state)
        ST_BOOT: begin
          state <= romDetected ? ST_LOAD : ST_IDLE;
        end
        ST_LOAD: begin
          if (romAck && loadLast) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          // clear goes first so a combined write reads byte zero
          if (addrClear) begin
            state <= ST_CLEAR;
          end else if (readGo) begin
            state <= ST_FETCH;
          end
        end
        ST_CLEAR: begin
          state <= ST_IDLE;
        end
        ST_FETCH: begin
          if (romAck) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_BOOT;
        end
      endcase
    end
  end

  assign romReq = (state == ST_LOAD) || (state == ST_FETCH);
  assign romAddr = (state == ST_LOAD) ? loadIdx : byteAddr;

  // strap caught one clock after reset release, never under reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      romPresent <= 1'b0;
    end else if (clkEn && state == ST_BOOT) begin
      romPresent <= romDetected;
    end
  end

  // ==========================================================
  // bus information block load
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loadIdx <= '0;
      busInfoBlock <= '0;
      busInfoValid <= 1'b0;
      miniFlag <= 1'b0;
    end else if (clkEn && state == ST_LOAD && romAck) begin
      busInfoBlock[int'(loadIdx) * 8 +: 8] <= romData;
      loadIdx <= loadIdx + 1'b1;
      if (loadIdx == ROM_AW'(`OIRR_MINI_BYTE)) begin
        miniFlag <= romData[`OIRR_MINI_BIT];
      end
      if (loadLast) begin
        busInfoValid <= 1'b1;
      end
    end
  end

  // ==========================================================
  // rom access control bits, software set wins over hardware clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addrClear <= 1'b0;
    end else if (clkEn) begin
      if (romWrite && romPresent && regWrData[`OIRR_CLEAR_BIT]) begin
        addrClear <= 1'b1;
      end else if (state == ST_CLEAR) begin
        addrClear <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readGo <= 1'b0;
    end else if (clkEn) begin
      if (romWrite && romPresent && regWrData[`OIRR_GO_BIT]) begin
        readGo <= 1'b1;
      end else if (state == ST_FETCH && romAck) begin
        readGo <= 1'b0;
      end
    end
  end

  // ==========================================================
  // rom byte address and read byte
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byteAddr <= '0;
      readByte <= 8'h00;
    end else if (clkEn) begin
      if (state == ST_CLEAR) begin
        byteAddr <= '0;
      end else if (state == ST_FETCH && romAck) begin
        byteAddr <= byteAddr + 1'b1;
        readByte <= romData;
      end
    end
  end

  // ==========================================================
  // retry limits register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      retryLimits <= `OIRR_RTRY_RESET;
    end else if (clkEn && rtryWrite) begin
      retryLimits <= regWrData[`OIRR_UNITS*4-1:0];
    end
  end

  // ==========================================================
  // per unit retry counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int u = 0; u < `OIRR_UNITS; u++) begin
        retryCnt[u] <= '0;
      end
      unitRetry <= '0;
      unitComplete <= '0;
      unitStatus <= '0;
    end else if (clkEn) begin
      for (int u = 0; u < `OIRR_UNITS; u++) begin
        unitRetry[u] <= 1'b0;
        unitComplete[u] <= 1'b0;
        if (unitAttemptDone[u]) begin
          if (unitAckRetryable[u] && retryCnt[u] < retryLimits[4*u +: 4]) begin
            unitRetry[u] <= 1'b1;
            retryCnt[u] <= retryCnt[u] + 1'b1;
          end else begin
            unitComplete[u] <= 1'b1;
            unitStatus[4*u +: 4] <= unitAckCode[4*u +: 4];
            retryCnt[u] <= '0;
          end
        end
      end
    end
  end

  // ==========================================================
  // register read
  always_comb begin
    readMux = 32'h0000_0000;
    if (hit(regAddr, `OIRR_VER_OFS)) begin
      readMux[`OIRR_PRESENT_BIT] = romPresent;
      readMux[`OIRR_BYTE_LSB +: 8] = `OIRR_MAJOR;
      readMux[7:0] = `OIRR_MINOR;
    end else if (hit(regAddr, `OIRR_ROM_OFS)) begin
      readMux[`OIRR_CLEAR_BIT] = addrClear;
      readMux[`OIRR_GO_BIT] = readGo;
      readMux[`OIRR_BYTE_LSB +: 8] = readByte;
      readMux[7:0] = miniFlag ? `OIRR_MINI_PTR : `OIRR_MINI_NONE;
    end else if (hit(regAddr, `OIRR_RTRY_OFS)) begin
      readMux[`OIRR_UNITS*4-1:0] = retryLimits;
    end
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 32'h0000_0000;
    end else if (clkEn) begin
      regRdData <= regRead ? readMux : 32'h0000_0000;
    end
  end

  // ==========================================================
  // checks
  property p_ver_rsvd;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRead && hit(regAddr, `OIRR_VER_OFS)
      |=> regRdData[31:25] == 7'h00 && regRdData[15:8] == 8'h00;
  endproperty
  a_ver_rsvd: assert property (p_ver_rsvd) else $error("version reserved bits set");
  property p_ver_present;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRead && hit(regAddr, `OIRR_VER_OFS)
      |=> regRdData[`OIRR_PRESENT_BIT] == $past(romPresent);
  endproperty
  a_ver_present: assert property (p_ver_present) else $error("present bit wrong");
  property p_load_needs_rom;
    @(posedge clk) disable iff (!rst_n)
    $rose(busInfoValid) |-> romPresent && state == ST_IDLE;
  endproperty
  a_load_needs_rom: assert property (p_load_needs_rom) else $error("load without rom");
  property p_ver_major;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRead && hit(regAddr, `OIRR_VER_OFS) |=> regRdData[23:16] == 8'h01;
  endproperty
  a_ver_major: assert property (p_ver_major) else $error("major version wrong");
  property p_ver_minor;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRead && hit(regAddr, `OIRR_VER_OFS) |=> regRdData[7:0] == 8'h10;
  endproperty
  a_ver_minor: assert property (p_ver_minor) else $error("minor version wrong");

  property p_clear_done;
    @(posedge clk) disable iff (!rst_n)
    clkEn && state == ST_IDLE && addrClear ##1 clkEn
      |=> byteAddr == '0 && (!addrClear || $past(romWrite));
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("address clear not done");
  property p_clear_keeps;
    @(posedge clk) disable iff (!rst_n)
    clkEn && state == ST_CLEAR |=> readByte == $past(readByte) && !romReq;
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) else $error("clear fetched a byte");
  property p_go_clears;
    @(posedge clk) disable iff (!rst_n)
    clkEn && state == ST_FETCH && romAck && !romWrite |=> !readGo;
  endproperty
  a_go_clears: assert property (p_go_clears) else $error("read go not cleared");
  property p_byte_lands;
    @(posedge clk) disable iff (!rst_n)
    clkEn && state == ST_FETCH && romAck ##1 clkEn && regRead && hit(regAddr, `OIRR_ROM_OFS)
      |=> regRdData[23:16] == $past(romData, 2);
  endproperty
  a_byte_lands: assert property (p_byte_lands) else $error("read byte not shown");
  property p_rom_rsvd;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRead && hit(regAddr, `OIRR_ROM_OFS)
      |=> regRdData[30:26] == 5'h00 && !regRdData[24] && regRdData[15:8] == 8'h00;
  endproperty
  a_rom_rsvd: assert property (p_rom_rsvd) else $error("rom reserved bits set");
  property p_mini;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRead && hit(regAddr, `OIRR_ROM_OFS)
      |=> regRdData[7:0] == ($past(miniFlag) ? 8'h20 : 8'h00);
  endproperty
  a_mini: assert property (p_mini) else $error("mini pointer wrong");

  property p_rtry_rsvd;
    @(posedge clk) disable iff (!rst_n)
    clkEn && regRead && hit(regAddr, `OIRR_RTRY_OFS)
      |=> regRdData[31:12] == 20'h00000 && regRdData[11:0] == $past(retryLimits);
  endproperty
  a_rtry_rsvd: assert property (p_rtry_rsvd) else $error("retry upper bits set");
  property p_phys_limit;
    @(posedge clk) disable iff (!rst_n)
    clkEn && unitAttemptDone[2] && unitAckRetryable[2] && retryCnt[2] < retryLimits[11:8]
      |=> unitRetry[2] && !unitComplete[2];
  endproperty
  a_phys_limit: assert property (p_phys_limit) else $error("phys unit no retry");
  property p_resp_limit;
    @(posedge clk) disable iff (!rst_n)
    clkEn && unitAttemptDone[1] && unitAckRetryable[1] && retryCnt[1] < retryLimits[7:4]
      |=> unitRetry[1] && !unitComplete[1];
  endproperty
  a_resp_limit: assert property (p_resp_limit) else $error("response unit no retry");
  property p_req_limit;
    @(posedge clk) disable iff (!rst_n)
    clkEn && unitAttemptDone[0] && unitAckRetryable[0] && retryCnt[0] < retryLimits[3:0]
      |=> unitRetry[0] && !unitComplete[0];
  endproperty
  a_req_limit: assert property (p_req_limit) else $error("request unit no retry");
  property p_give_up;
    @(posedge clk) disable iff (!rst_n)
    clkEn && unitAttemptDone[0] && (!unitAckRetryable[0] || retryCnt[0] >= retryLimits[3:0])
      |=> unitComplete[0] && !unitRetry[0] && unitStatus[3:0] == $past(unitAckCode[3:0])
          && retryCnt[0] == '0;
  endproperty
  a_give_up: assert property (p_give_up) else $error("unit did not give up");

  property p_addr_step;
    @(posedge clk) disable iff (!rst_n)
    clkEn && state == ST_FETCH && romAck |=> byteAddr == $past(byteAddr) + 1'b1;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("rom address not advanced");

endmodule // oirr_regs

`default_nettype wire

// ===== oirr_rom_model.sv
`default_nettype none

// ==========================================================
// serial rom byte store, answers each request after a delay
module oirr_rom_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // byte port
  input wire logic romReq,
  input wire logic [7:0] romAddr,
  output logic romAck,
  output logic [7:0] romData,
  // wait cycles before each answer
  input wire logic [3:0] delay
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] waitCount;

  // data only valid with the ack; otherwise it keeps toggling
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      romAck <= 1'b0;
      romData <= 8'h00;
      waitCount <= 4'h0;
    end else if (romReq && !romAck && waitCount >= delay) begin
      romAck <= 1'b1;
      romData <= romAddr ^ 8'ha5;
      waitCount <= 4'h0;
    end else begin
      romAck <= 1'b0;
      romData <= ~romData;
      waitCount <= (romReq && !romAck) ? waitCount + 4'h1 : 4'h0;
    end
  end
endmodule // oirr_rom_model

`default_nettype wire

// ===== ohci_id_rom_retry_regs_bench.sv
`include "oirr_defines.svh"
`default_nettype none

module ohci_id_rom_retry_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic romDetected = 1'b0;
  logic romReq;
  logic romAck;
  logic [7:0] romAddr;
  logic [7:0] romData;
  logic [3:0] romDelay = 4'h0;
  logic [127:0] busInfoBlock;
  logic busInfoValid;
  logic [2:0] unitAttemptDone = 3'h0;
  logic [2:0] unitAckRetryable = 3'h0;
  logic [11:0] unitAckCode = 12'h0;
  logic [2:0] unitRetry;
  logic [2:0] unitComplete;
  logic [11:0] unitStatus;
  int badCount = 0;
  int totalChecks = 0;

  always #5 clk = ~clk;

  oirr_regs #(.ROM_AW(8), .BIB_BYTES(16)) dut (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRead(regRead), .regRdData(regRdData),
    .romDetected(romDetected), .romReq(romReq), .romAddr(romAddr),
    .romAck(romAck), .romData(romData),
    .busInfoBlock(busInfoBlock), .busInfoValid(busInfoValid),
    .unitAttemptDone(unitAttemptDone), .unitAckRetryable(unitAckRetryable),
    .unitAckCode(unitAckCode), .unitRetry(unitRetry),
    .unitComplete(unitComplete), .unitStatus(unitStatus)
  );

  oirr_rom_model rom (
    .clk(clk), .rst_n(rst_n), .romReq(romReq), .romAddr(romAddr),
    .romAck(romAck), .romData(romData), .delay(romDelay)
  );

  // ==========================================================
  // helpers
  function automatic logic [7:0] romByte(input int k);
    return 8'(k) ^ 8'ha5;
  endfunction

  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 chk(regRdData, exp, what);
  endtask

  // polls until the pending bit drops, bounded
  task automatic waitClear(input int pos);
    int n;
    for (n = 0; n < 40 && dut.regRdData[pos] !== 1'b0 || n == 0; n++) begin
      @(posedge clk);
      regAddr <= `OIRR_ROM_OFS;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
    end
    chk({31'h0, regRdData[pos]}, 32'h0, "pending bit");
  endtask

  task automatic romRead(input logic [31:0] cmd, input int k);
    wr(`OIRR_ROM_OFS, cmd);
    waitClear(`OIRR_GO_BIT);
    rdChk(`OIRR_ROM_OFS, {8'h00, romByte(k), 16'h0020}, "rom byte");
  endtask

  task automatic attempt(input int u, input logic retry, input logic [3:0] ack, input logic expR);
    logic [2:0] one;
    one = 3'(1 << u);
    @(posedge clk);
    unitAttemptDone <= one;
    unitAckRetryable <= retry ? one : 3'h0;
    unitAckCode <= {3{ack}};
    @(posedge clk);
    unitAttemptDone <= 3'h0;
    #1 chk({26'h0, unitRetry, unitComplete}, {26'h0, expR ? one : 3'h0, expR ? 3'h0 : one},
      "unit answer");
    if (!expR) chk({28'h0, unitStatus[4*u +: 4]}, {28'h0, ack}, "unit status");
  endtask

  // ==========================================================
  // tests
  initial begin
    int n;
    int lim;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdChk(`OIRR_VER_OFS, 32'h00010010, "version bare");
    rdChk(`OIRR_ROM_OFS, 32'h00000000, "rom reg bare");
    wr(`OIRR_ROM_OFS, 32'h82000000);
    for (n = 0; n < 10; n++) begin
      @(posedge clk);
      #1 chk({31'h0, romReq}, 32'h0, "no rom traffic");
    end
    $display("test no_rom done");

    @(posedge clk);
    rst_n <= 1'b0;
    romDetected <= 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (n = 0; n < 400 && busInfoValid !== 1'b1; n++) @(posedge clk);
    chk({31'h0, busInfoValid}, 32'h1, "boot load");
    for (n = 0; n < 16; n++) begin
      chk({24'h0, busInfoBlock[8*n +: 8]}, {24'h0, romByte(n)}, "info byte");
    end
    rdChk(`OIRR_VER_OFS, 32'h01010010, "version rom");
    $display("test boot done");

    romRead(32'h82000000, 0);
    romDelay <= 4'h6;
    for (n = 1; n < 4; n++) romRead(32'h02000000, n);
    wr(`OIRR_ROM_OFS, 32'h80000000);
    waitClear(`OIRR_CLEAR_BIT);
    rdChk(`OIRR_ROM_OFS, {8'h00, romByte(3), 16'h0020}, "byte kept");
    wr(`OIRR_ROM_OFS, 32'h7dffffff);
    rdChk(`OIRR_ROM_OFS, {8'h00, romByte(3), 16'h0020}, "ro bits");
    romRead(32'h02000000, 0);
    $display("test rom_read done");

    rdChk(`OIRR_RTRY_OFS, 32'h0, "retry reset");
    wr(`OIRR_RTRY_OFS, 32'hffffffff);
    rdChk(`OIRR_RTRY_OFS, 32'h00000fff, "retry ro");
    wr(8'h0c, 32'hffffffff);
    rdChk(8'h0c, 32'h0, "unmapped");
    wr(`OIRR_VER_OFS, 32'hffffffff);
    rdChk(`OIRR_VER_OFS, 32'h01010010, "version ro");
    wr(`OIRR_RTRY_OFS, 32'h00000132);
    rdChk(`OIRR_RTRY_OFS, 32'h00000132, "limits");
    for (int u = 0; u < 3; u++) begin
      lim = (u == 0) ? 2 : ((u == 1) ? 3 : 1);
      for (n = 0; n <= lim; n++) begin
        attempt(u, 1'b1, 4'(n + 3), n < lim);
      end
      attempt(u, 1'b0, 4'h1, 1'b0);
    end
    // limit zero: first busy answer already completes
    wr(`OIRR_RTRY_OFS, 32'h00000000);
    attempt(1, 1'b1, 4'h7, 1'b0);
    // a write while the enable is low must be lost
    @(posedge clk);
    clkEn <= 1'b0;
    wr(`OIRR_RTRY_OFS, 32'h00000abc);
    clkEn <= 1'b1;
    rdChk(`OIRR_RTRY_OFS, 32'h00000000, "frozen write");
    $display("test retry done");
    closeOut();
  end

  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    $display("Error at %0t: watchdog expired", $time);
    closeOut();
  end
endmodule // ohci_id_rom_retry_regs_bench

`default_nettype wire
